// ==== rtl/bcal_map.svh ====
// Register addresses, field positions, reset values and prescaler counts of the calendar clock
`ifndef BCAL_MAP_SVH
`define BCAL_MAP_SVH

// ----------------------------------------------------------------
// Host addresses
// ----------------------------------------------------------------
`define BCAL_A_SEC 3'h2
`define BCAL_A_MIN 3'h3
`define BCAL_A_HR 3'h4
`define BCAL_A_DAY 3'h5
`define BCAL_A_MON 3'h6
`define BCAL_A_CTRL 3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BCAL_CTL_FSEL_LSB 0
`define BCAL_CTL_START 2
`define BCAL_CTL_ALARM 3
`define BCAL_CTL_RATE_LSB 4
`define BCAL_ST_ALARM 7
`define BCAL_ST_CLK 6
`define BCAL_HR_PM 7
`define BCAL_HR_12 6
`define BCAL_MON_LEAP 7

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define BCAL_CTRL_RST 8'h00
`define BCAL_SEC_RST 8'h00
`define BCAL_MIN_RST 8'h00
`define BCAL_HR_RST 8'h00
`define BCAL_DAY_RST 8'h01
`define BCAL_MON_RST 8'h01
`define BCAL_SEC_MAX 8'h59
`define BCAL_MON_MAX 8'h12
`define BCAL_HALF_MIN 8'h30

// ----------------------------------------------------------------
// Prescaler: oscillator edges per second as powers of two
// ----------------------------------------------------------------
`define BCAL_LOG2_F32K 15
`define BCAL_LOG2_F1M 20
`define BCAL_LOG2_F2M 21
`define BCAL_LOG2_F4M 22
`define BCAL_SQ_OFFSET 13
`define BCAL_RATE_OFF 4'h0
`define BCAL_RATE_FAST_MAX 4'hB
`define BCAL_RATE_SEC 4'hC
`define BCAL_RATE_MIN 4'hD
`define BCAL_RATE_HOUR 4'hE

`endif

// ==== rtl/bcal_pkg.sv ====
// Types shared by the calendar clock modules
package bcal_pkg;

  typedef enum logic [1:0] {
    BCAL_ACC_IDLE = 2'b00,
    BCAL_ACC_RD = 2'b01,
    BCAL_ACC_WR = 2'b10
  } bcal_acc_t;

  typedef logic [7:0] bcal_bcd_t;

endpackage

// ==== rtl/bcal_bcd_cnt.sv ====
// Loadable two-digit BCD counter with programmable wrap limits
`timescale 1ns/1ps
module bcal_bcd_cnt #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic inc,
  input wire logic ld,
  input wire logic [7:0] ld_val,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  // Result
  output logic [7:0] q,
  output logic wrap
);

  bcal_pkg::bcal_bcd_t q_q;
  bcal_pkg::bcal_bcd_t q_d;

  always_comb begin
    q_d = q_q;
    if (ld) begin
      q_d = ld_val;
    end else if (inc) begin
      // At or past the limit wraps, so an illegal loaded value recovers
      if (q_q >= hi) begin
        q_d = lo;
      end else if (q_q[3:0] >= 4'h9) begin
        q_d = {4'(q_q[7:4] + 4'h1), 4'h0};
      end else begin
        q_d = {q_q[7:4], 4'(q_q[3:0] + 4'h1)};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_q <= RST_VAL;
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;
  assign wrap = inc & ~ld & (q_q >= hi);

endmodule // bcal_bcd_cnt

// ==== rtl/bcal_clock.sv ====
// BCD time-of-day and calendar clock with alarm, square-wave output and interrupt
`timescale 1ns/1ps
`include "bcal_map.svh"
module bcal_clock #(
  parameter int LOG2_F32K = `BCAL_LOG2_F32K,
  parameter int LOG2_F1M = `BCAL_LOG2_F1M,
  parameter int LOG2_F2M = `BCAL_LOG2_F2M,
  parameter int LOG2_F4M = `BCAL_LOG2_F4M
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Counting oscillator pin
  input wire logic osc_in,
  // Host bus pins
  input wire logic bus_cs,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_d_in,
  output logic [7:0] bus_d_out,
  output logic bus_d_oe_n,
  // Mode pin
  input wire logic power_down,
  // Interrupt and square-wave pins
  output logic int_n,
  output logic int_oe_n,
  output logic clk_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 16;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
    end else begin
      s1_q <= {osc_in, bus_cs, bus_rd, bus_wr, power_down, bus_addr, bus_d_in};
      s2_q <= s1_q;
    end
  end

  logic osc_s;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic pd_s;
  logic [2:0] addr_s;
  logic [7:0] din_s;
  assign {osc_s, cs_s, rd_s, wr_s, pd_s, addr_s, din_s} = s2_q;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bcal_pkg::bcal_acc_t acc_q, acc_d;
  logic osc_prev_q, osc_prev_d;
  logic [21:0] pre_q, pre_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [2:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] dout_q, dout_d;
  logic doe_n_q, doe_n_d;
  logic pend_q, pend_d;
  logic adv_q, adv_d;
  logic [7:0] hr_q, hr_d;
  logic leap_q, leap_d;
  logic [7:0] al_sec_q, al_sec_d;
  logic [7:0] al_min_q, al_min_d;
  logic [7:0] al_hr_q, al_hr_d;
  logic [2:0] al_en_q, al_en_d;
  logic st_al_q, st_al_d;
  logic st_ck_q, st_ck_d;
  logic sq_prev_q, sq_prev_d;
  logic clk_out_q, clk_out_d;
  logic int_n_q, int_n_d;
  logic int_oe_n_q, int_oe_n_d;

  // Combinational strobes into the counters
  logic adv;
  logic commit;
  logic to_cnt;
  logic ld_sec;
  logic ld_min;
  logic ld_day;
  logic ld_mon;
  logic day_inc;
  logic [7:0] day_len;
  logic [7:0] mon_ld_val;
  logic [7:0] sec_v;
  logic [7:0] min_v;
  logic [7:0] day_v;
  logic [7:0] mon_v;
  logic sec_wrap;
  logic min_wrap;
  logic day_wrap;

  bcal_bcd_cnt #(.RST_VAL(`BCAL_SEC_RST)) u_sec (
    .clk(clk), .rst_n(rst_n), .inc(adv), .ld(ld_sec), .ld_val(wdata_q),
    .lo(8'h00), .hi(`BCAL_SEC_MAX), .q(sec_v), .wrap(sec_wrap)
  );
  bcal_bcd_cnt #(.RST_VAL(`BCAL_MIN_RST)) u_min (
    .clk(clk), .rst_n(rst_n), .inc(sec_wrap), .ld(ld_min), .ld_val(wdata_q),
    .lo(8'h00), .hi(`BCAL_SEC_MAX), .q(min_v), .wrap(min_wrap)
  );
  bcal_bcd_cnt #(.RST_VAL(`BCAL_DAY_RST)) u_day (
    .clk(clk), .rst_n(rst_n), .inc(day_inc), .ld(ld_day), .ld_val(wdata_q),
    .lo(8'h01), .hi(day_len), .q(day_v), .wrap(day_wrap)
  );
  bcal_bcd_cnt #(.RST_VAL(`BCAL_MON_RST)) u_mon (
    .clk(clk), .rst_n(rst_n), .inc(day_wrap), .ld(ld_mon), .ld_val(mon_ld_val),
    .lo(8'h01), .hi(`BCAL_MON_MAX), .q(mon_v), .wrap()
  );

  function automatic logic [5:0] inc6(input logic [5:0] v);
    if (v[3:0] >= 4'h9) begin
      inc6 = {2'(v[5:4] + 2'h1), 4'h0};
    end else begin
      inc6 = {v[5:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    int m;
    int idx;
    logic [22:0] span;
    logic [21:0] mask;
    logic tick;
    logic frozen;
    logic clr;
    logic match;
    logic sq;
    logic pm;
    logic [5:0] hv;
    logic [3:0] rate;
    m = LOG2_F32K;
    idx = 0;
    span = 23'h000000;
    mask = 22'h000000;
    tick = 1'b0;
    frozen = 1'b0;
    clr = 1'b0;
    match = 1'b0;
    sq = 1'b0;
    pm = hr_q[`BCAL_HR_PM];
    hv = hr_q[5:0];
    rate = ctrl_q[`BCAL_CTL_RATE_LSB +: 4];

    // Prescaler: divisor chosen by the frequency field
    case (ctrl_q[`BCAL_CTL_FSEL_LSB +: 2])
      2'b00: m = LOG2_F32K;
      2'b01: m = LOG2_F1M;
      2'b10: m = LOG2_F2M;
      default: m = LOG2_F4M;
    endcase
    span = (23'h000001 << m) - 23'h000001;
    mask = span[21:0];
    osc_prev_d = osc_s;
    pre_d = pre_q;
    if (ctrl_q[`BCAL_CTL_START] && osc_s && !osc_prev_q) begin
      if ((pre_q & mask) == mask) begin
        pre_d = 22'h000000;
        tick = 1'b1;
      end else begin
        pre_d = 22'(pre_q + 22'h000001);
      end
    end

    // Host access sequencer; power-down drops every access
    acc_d = acc_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    commit = 1'b0;
    if (pd_s) begin
      acc_d = bcal_pkg::BCAL_ACC_IDLE;
    end else begin
      unique case (acc_q)
        bcal_pkg::BCAL_ACC_IDLE: begin
          if (cs_s && wr_s) begin
            acc_d = bcal_pkg::BCAL_ACC_WR;
            addr_d = addr_s;
            wdata_d = din_s;
          end else if (cs_s && rd_s) begin
            acc_d = bcal_pkg::BCAL_ACC_RD;
            addr_d = addr_s;
          end
        end
        bcal_pkg::BCAL_ACC_WR: begin
          if (cs_s && wr_s) begin
            addr_d = addr_s;
            wdata_d = din_s;
          end else begin
            acc_d = bcal_pkg::BCAL_ACC_IDLE;
            commit = 1'b1;
          end
        end
        bcal_pkg::BCAL_ACC_RD: begin
          if (!(cs_s && rd_s)) begin
            acc_d = bcal_pkg::BCAL_ACC_IDLE;
            clr = (addr_q == `BCAL_A_CTRL);
          end
        end
        default: acc_d = bcal_pkg::BCAL_ACC_IDLE;
      endcase
    end

    // Freeze: a second boundary during an access waits until it ends
    frozen = (acc_q != bcal_pkg::BCAL_ACC_IDLE);
    adv = 1'b0;
    pend_d = pend_q;
    if (tick || pend_q) begin
      if (frozen) begin
        pend_d = 1'b1;
      end else begin
        adv = 1'b1;
        pend_d = 1'b0;
      end
    end
    adv_d = adv;

    // Second, minute and hour writes go to counters or alarm latches by the load-target bit; day and month writes always load the counters
    to_cnt = ~ctrl_q[`BCAL_CTL_ALARM];
    ld_sec = commit && addr_q == `BCAL_A_SEC && to_cnt;
    ld_min = commit && addr_q == `BCAL_A_MIN && to_cnt;
    ld_day = commit && addr_q == `BCAL_A_DAY;
    ld_mon = commit && addr_q == `BCAL_A_MON;
    mon_ld_val = {1'b0, wdata_q[6:0]};
    ctrl_d = ctrl_q;
    al_sec_d = al_sec_q;
    al_min_d = al_min_q;
    al_hr_d = al_hr_q;
    al_en_d = al_en_q;
    leap_d = leap_q;
    if (commit && addr_q == `BCAL_A_CTRL) begin
      ctrl_d = wdata_q;
      if (wdata_q[`BCAL_CTL_ALARM]) begin
        al_en_d = 3'b000;
      end
    end
    if (commit && !to_cnt) begin
      if (addr_q == `BCAL_A_SEC) begin
        al_sec_d = wdata_q;
        al_en_d[0] = 1'b1;
      end
      if (addr_q == `BCAL_A_MIN) begin
        al_min_d = wdata_q;
        al_en_d[1] = 1'b1;
      end
      if (addr_q == `BCAL_A_HR) begin
        al_hr_d = wdata_q;
        al_en_d[2] = 1'b1;
      end
    end
    if (ld_mon) begin
      leap_d = wdata_q[`BCAL_MON_LEAP];
    end

    // Hours in 12- or 24-hour form, carrying into the day
    hr_d = hr_q;
    day_inc = 1'b0;
    if (commit && addr_q == `BCAL_A_HR && to_cnt) begin
      hr_d = wdata_q;
    end else if (min_wrap) begin
      if (hr_q[`BCAL_HR_12]) begin
        if (hv == 6'h11) begin
          hr_d = {~pm, 1'b1, 6'h12};
          day_inc = pm;
        end else if (hv >= 6'h12) begin
          hr_d = {pm, 1'b1, 6'h01};
        end else begin
          hr_d = {pm, 1'b1, inc6(hv)};
        end
      end else if (hv >= 6'h23) begin
        hr_d = 8'h00;
        day_inc = 1'b1;
      end else begin
        hr_d = {2'b00, inc6(hv)};
      end
    end

    // Month length with the leap-year February
    case (mon_v)
      8'h02: day_len = leap_q ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: day_len = 8'h30;
      default: day_len = 8'h31;
    endcase

    // Alarm compare, one cycle after the counters step
    match = ctrl_q[`BCAL_CTL_ALARM] && (al_en_q != 3'b000)
      && (!al_en_q[0] || sec_v == al_sec_q)
      && (!al_en_q[1] || min_v == al_min_q)
      && (!al_en_q[2] || {hr_q[7], hr_q[5:0]} == {al_hr_q[7], al_hr_q[5:0]});

    // Square-wave select
    idx = m - `BCAL_SQ_OFFSET + int'(rate);
    if (rate == `BCAL_RATE_OFF) begin
      sq = 1'b0;
    end else if (rate <= `BCAL_RATE_FAST_MAX) begin
      sq = pre_q[idx];
    end else if (rate == `BCAL_RATE_SEC) begin
      sq = pre_q[m - 1];
    end else if (rate == `BCAL_RATE_MIN) begin
      sq = sec_v < `BCAL_HALF_MIN;
    end else if (rate == `BCAL_RATE_HOUR) begin
      sq = min_v < `BCAL_HALF_MIN;
    end else begin
      sq = hr_q[`BCAL_HR_12] ? ~pm : (hv < 6'h12);
    end
    sq_prev_d = sq;
    clk_out_d = sq;

    // Sticky sources; a new event wins over the read that clears it
    st_al_d = (adv_q && match) || (st_al_q && !clr);
    st_ck_d = (sq && !sq_prev_q) || (st_ck_q && !clr);
    int_n_d = ~(st_al_q | st_ck_q);
    int_oe_n_d = pd_s;

    // Read data, driven only while a read is in progress
    doe_n_d = (acc_d != bcal_pkg::BCAL_ACC_RD);
    case (addr_d)
      `BCAL_A_SEC: dout_d = sec_v;
      `BCAL_A_MIN: dout_d = min_v;
      `BCAL_A_HR: dout_d = hr_q;
      `BCAL_A_DAY: dout_d = day_v;
      `BCAL_A_MON: dout_d = {leap_q, mon_v[6:0]};
      `BCAL_A_CTRL: dout_d = {st_al_q, st_ck_q, 6'h00};
      default: dout_d = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= bcal_pkg::BCAL_ACC_IDLE;
      osc_prev_q <= 1'b0;
      pre_q <= 22'h000000;
      ctrl_q <= `BCAL_CTRL_RST;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      dout_q <= 8'h00;
      doe_n_q <= 1'b1;
      pend_q <= 1'b0;
      adv_q <= 1'b0;
      hr_q <= `BCAL_HR_RST;
      leap_q <= 1'b0;
      al_sec_q <= 8'h00;
      al_min_q <= 8'h00;
      al_hr_q <= 8'h00;
      al_en_q <= 3'b000;
      st_al_q <= 1'b0;
      st_ck_q <= 1'b0;
      sq_prev_q <= 1'b0;
      clk_out_q <= 1'b0;
      int_n_q <= 1'b1;
      int_oe_n_q <= 1'b1;
    end else begin
      acc_q <= acc_d;
      osc_prev_q <= osc_prev_d;
      pre_q <= pre_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      dout_q <= dout_d;
      doe_n_q <= doe_n_d;
      pend_q <= pend_d;
      adv_q <= adv_d;
      hr_q <= hr_d;
      leap_q <= leap_d;
      al_sec_q <= al_sec_d;
      al_min_q <= al_min_d;
      al_hr_q <= al_hr_d;
      al_en_q <= al_en_d;
      st_al_q <= st_al_d;
      st_ck_q <= st_ck_d;
      sq_prev_q <= sq_prev_d;
      clk_out_q <= clk_out_d;
      int_n_q <= int_n_d;
      int_oe_n_q <= int_oe_n_d;
    end
  end

  assign bus_d_out = dout_q;
  assign bus_d_oe_n = doe_n_q;
  assign int_n = int_n_q;
  assign int_oe_n = int_oe_n_q;
  assign clk_out = clk_out_q;

endmodule // bcal_clock

// ==== sim/bcal_host_model.sv ====
// Host bus master model for the calendar clock's strobe bus
`timescale 1ns/1ps
module bcal_host_model (
  // Clock
  input wire logic clk,
  // Bus pins
  output logic bus_cs,
  output logic bus_rd,
  output logic bus_wr,
  output logic [2:0] bus_addr,
  output logic [7:0] bus_d_in,
  input wire logic [7:0] bus_d_out,
  input wire logic bus_d_oe_n
);
  // Strobe hold in clocks; 4 or more keeps address and data settled
  int unsigned hold_cyc = 4;
  initial begin
    bus_cs = 1'b0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 3'h0;
    bus_d_in = 8'h00;
  end
  task automatic start(input logic [2:0] a, input logic w);
    @(posedge clk);
    #1;
    bus_addr = a;
    bus_cs = 1'b1;
    bus_wr = w;
    bus_rd = !w;
  endtask
  task automatic finish();
    #1;
    bus_cs = 1'b0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    start(a, 1'b1);
    bus_d_in = d;
    repeat (hold_cyc) @(posedge clk);
    finish();
    // Released data must not keep showing the last byte
    bus_d_in = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output bit ok);
    int n;
    n = 0;
    start(a, 1'b0);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (bus_d_oe_n !== 1'b0 && n < 20);
    ok = (n < 20);
    d = bus_d_out;
    repeat (hold_cyc) @(posedge clk);
    finish();
  endtask
endmodule  // bcal_host_model

// ==== sim/bcal_clock_properties.sv ====
// Concurrent checks on the calendar clock's pins
`timescale 1ns/1ps
module bcal_clock_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host bus pins
  input wire logic bus_cs,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_d_out,
  input wire logic bus_d_oe_n,
  // Mode and output pins
  input wire logic power_down,
  input wire logic int_n,
  input wire logic int_oe_n,
  input wire logic clk_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd_held;
    (bus_cs && bus_rd && !power_down)[*4];
  endsequence
  sequence s_rd_at(logic [2:0] a);
    (bus_cs && bus_rd && !power_down && bus_addr == a)[*5];
  endsequence
  property p_rd_answer;
    s_rd_held |-> !bus_d_oe_n;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_release;
    (!bus_rd)[*4] |-> bus_d_oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("bus still driven");
  property p_wr_quiet;
    (bus_cs && bus_wr)[*4] |-> bus_d_oe_n;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven in write");
  property p_unmapped;
    s_rd_at(3'h0) or s_rd_at(3'h1) |-> bus_d_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_st_low;
    s_rd_at(3'h7) |-> bus_d_out[5:0] == 6'h00;
  endproperty
  a_st_low: assert property (p_st_low) else $error("status low bits set");
  property p_pd_float;
    power_down[*4] |-> int_oe_n;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("interrupt driven in pd");
  property p_pd_bus;
    power_down[*4] |-> bus_d_oe_n;
  endproperty
  a_pd_bus: assert property (p_pd_bus) else $error("bus driven in pd");
  property p_run_drive;
    (!power_down)[*4] |-> !int_oe_n;
  endproperty
  a_run_drive: assert property (p_run_drive) else $error("interrupt not driven");
  property p_sq_int;
    (!power_down)[*4] ##0 $rose(clk_out) |-> ##[1:4] !int_n;
  endproperty
  a_sq_int: assert property (p_sq_int) else $error("square edge no interrupt");
  property p_int_sticky;
    (!int_n && !bus_rd && !power_down)[*8] |=> !int_n;
  endproperty
  a_int_sticky: assert property (p_int_sticky) else $error("interrupt lost");
endmodule  // bcal_clock_properties

bind bcal_clock bcal_clock_properties bcal_clock_properties_i (
  .clk, .rst_n, .bus_cs, .bus_rd, .bus_wr, .bus_addr, .bus_d_out,
  .bus_d_oe_n, .power_down, .int_n, .int_oe_n, .clk_out
);

// ==== sim/tb_bcal_clock.sv ====
// Self-checking bench for the calendar clock
`timescale 1ns/1ps
`include "bcal_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_bcal_clock;
  // Short second keeps the run small: 2^12 osc edges of 6 clocks
  localparam int LG = 12;
  localparam int SEC_CYC = 6 << LG;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_in = 1'b0;
  logic power_down = 1'b0;
  logic bus_cs, bus_rd, bus_wr, bus_d_oe_n, int_n, int_oe_n, clk_out;
  logic [2:0] bus_addr;
  logic [7:0] bus_d_in, bus_d_out, rv;
  bit ok;
  int failures = 0;
  int checked = 0;
  int n, v;
  always #10 clk = ~clk;
  // Fastest osc the sync flops allow
  always begin
    repeat (3) @(posedge clk);
    #1;
    osc_in = ~osc_in;
  end
  // Selects one octave apart, so a wrong divisor shows in the period
  bcal_clock #(.LOG2_F32K(LG), .LOG2_F1M(LG + 1), .LOG2_F2M(LG + 2),
    .LOG2_F4M(LG + 3)) bcal_clock_i (
    .clk, .rst_n, .osc_in, .bus_cs, .bus_rd, .bus_wr, .bus_addr, .bus_d_in,
    .bus_d_out, .bus_d_oe_n, .power_down, .int_n, .int_oe_n, .clk_out);
  bcal_host_model bcal_host_model_i (
    .clk, .bus_cs, .bus_rd, .bus_wr, .bus_addr, .bus_d_in, .bus_d_out, .bus_d_oe_n);
  // ----
  // Helpers
  // ----
  task automatic give_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [7:0] to_bcd(input int x);
    return {4'(x / 10), 4'(x % 10)};
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bcal_host_model_i.wr(a, d);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    bcal_host_model_i.rd(a, rv, ok);
    `CHK(ok, 1'b1)
    `CHK(rv, e)
  endtask
  task automatic load5(input logic [7:0] d[5]);
    for (int i = 0; i < 5; i++) begin
      wr(3'(`BCAL_A_SEC + i), d[i]);
    end
  endtask
  task automatic chk5(input logic [7:0] e[5]);
    for (int i = 0; i < 5; i++) begin
      rd_chk(3'(`BCAL_A_SEC + i), e[i]);
    end
  endtask
  task automatic set_pd(input logic b);
    @(posedge clk);
    #1;
    power_down = b;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_rise(output int k);
    logic pv;
    k = 0;
    do begin
      pv = clk_out;
      @(posedge clk);
      #1;
      k++;
    end while (!(pv === 1'b0 && clk_out === 1'b1) && k < 3000);
  endtask
  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(98));
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    chk5('{`BCAL_SEC_RST, `BCAL_MIN_RST, `BCAL_HR_RST, `BCAL_DAY_RST, `BCAL_MON_RST});
    rd_chk(`BCAL_A_CTRL, 8'h00);
    rd_chk(3'h0, 8'h00);
    `CHK(int_oe_n, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      v = $urandom_range(i % 3 == 2 ? 23 : 59);
      bcal_host_model_i.hold_cyc = $urandom_range(8, 4);
      wr(3'(`BCAL_A_SEC + i % 3), to_bcd(v));
      rd_chk(3'(`BCAL_A_SEC + i % 3), to_bcd(v));
    end
    $display("test load done");
    for (int c = 1; c < 7; c++) begin
      wr(`BCAL_A_CTRL, {4'(c), 4'h4 | 4'(c % 4)});
      wait_rise(n);
      wait_rise(n);
      wait_rise(n);
      `CHK(n, 6 << (c + c % 4))
    end
    wr(`BCAL_A_CTRL, 8'h04);
    repeat (4) @(posedge clk);
    `CHK(clk_out, 1'b0)
    rd_chk(`BCAL_A_CTRL, 8'h40);
    rd_chk(`BCAL_A_CTRL, 8'h00);
    `CHK(int_n, 1'b1)
    $display("test square done");
    wr(`BCAL_A_MIN, 8'h21);
    wr(`BCAL_A_CTRL, 8'h14);
    set_pd(1'b1);
    `CHK(int_oe_n, 1'b1)
    wait_rise(n);
    wait_rise(n);
    `CHK(n, 12)
    wr(`BCAL_A_MIN, 8'h33);
    bcal_host_model_i.rd(`BCAL_A_MIN, rv, ok);
    `CHK(ok, 1'b0)
    set_pd(1'b0);
    `CHK(int_n, 1'b0)
    rd_chk(`BCAL_A_MIN, 8'h21);
    rd_chk(`BCAL_A_CTRL, 8'h40);
    $display("test power down done");
    wr(`BCAL_A_CTRL, 8'h00);
    load5('{8'h58, 8'h59, 8'h23, 8'h31, 8'h12});
    wr(`BCAL_A_CTRL, 8'h0C);
    wr(`BCAL_A_SEC, 8'h59);
    wr(`BCAL_A_MIN, 8'h59);
    bcal_host_model_i.rd(`BCAL_A_CTRL, rv, ok);
    n = 0;
    while (int_n !== 1'b0 && n < SEC_CYC + 2000) begin
      @(posedge clk);
      n++;
    end
    `CHK(int_n, 1'b0)
    rd_chk(`BCAL_A_CTRL, 8'h80);
    rd_chk(`BCAL_A_SEC, 8'h59);
    // Read held across the next tick: count stays frozen, carry lands after
    repeat (SEC_CYC - 200) @(posedge clk);
    bcal_host_model_i.start(`BCAL_A_SEC, 1'b0);
    repeat (400) @(posedge clk);
    `CHK(bus_d_out, 8'h59)
    bcal_host_model_i.finish();
    chk5('{8'h00, 8'h00, 8'h00, 8'h01, 8'h01});
    rd_chk(`BCAL_A_CTRL, 8'h00);
    $display("test alarm and wrap done");
    wr(`BCAL_A_CTRL, 8'h04);
    load5('{8'h59, 8'h59, 8'hD1, 8'h28, 8'h82});
    repeat (SEC_CYC) @(posedge clk);
    chk5('{8'h00, 8'h00, 8'h52, 8'h29, 8'h82});
    $display("test leap done");
    give_verdict();
  end
  initial begin
    repeat (4 * SEC_CYC) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule  // tb_bcal_clock
